// ### pkg/co2ai_pkg.sv
// Summary of operation
// - Relay closes above setpoint plus 50 ppm (never reached at position 9 in the narrow range), opens below setpoint minus 50 ppm.
// - Rotary position 0 to 9 selects setpoint 600 to 2000 ppm; position 0 default.
// - Relay indicator LED is lit exactly while the relay is closed.
// - Top LED steady for 1200 to 2000 ppm, blinking above 2000 ppm in the wide range, steady in the narrow range.
// - Middle LED lit for 800 to 1200 ppm, dark otherwise.
// - Bottom LED lit for 0 to 800 ppm, dark otherwise.
// - Air quality is good to 800, fair to 1200, poor above 1200 ppm.
// - On a fault, readings show stars, with alarm symbol and error message.
// - Several active faults are rotated, each shown for one screen time.
// - Power-on shows info screen with module number when present and OK or ERROR.
// - A startup error cause is shown on the measurement screen afterwards.
// - Each active analog output gets its own configuration screen after the info screen.
// - After startup screens the measurement screen with air quality class is shown.
// - Range switch selects 0 to 2000 or 0 to 5000 ppm; wide is default.
// - Temperature is presented in degrees Celsius only.
package co2ai_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned SCREEN_MS  = 3000;
	localparam int unsigned BLINK_MS   = 500;
	localparam int unsigned SCREEN_CYC = SCREEN_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_CYC  = BLINK_MS * (CLK_HZ / 1000);

	// ==========================================================
	// Levels in ppm
	localparam logic [15:0] HYST_PPM    = 16'h0032;
	localparam logic [15:0] LVL_LOW     = 16'h0320;
	localparam logic [15:0] LVL_HIGH    = 16'h04B0;
	localparam logic [15:0] LVL_TOP     = 16'h07D0;
	localparam logic [15:0] SPAN_NARROW = 16'h07D0;
	localparam logic [15:0] SPAN_WIDE   = 16'h1388;
	localparam logic [15:0] SETPT_TAB [10] = '{16'h0258, 16'h02BC, 16'h0320, 16'h0384,
		16'h03E8, 16'h04B0, 16'h0578, 16'h0640, 16'h0708, 16'h07D0};

	// ==========================================================
	// Register map
	localparam logic [7:0]  ADDR_CONC    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS  = 8'h04;
	localparam logic [7:0]  ADDR_OUTCFG  = 8'h08;
	localparam logic [7:0]  ADDR_SETPT   = 8'h0C;
	localparam logic [7:0]  ADDR_TEMP    = 8'h10;
	localparam logic [1:0]  OUTCFG_RST   = 2'h1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [3:0]  FAULT_NOMOD  = 4'h1;
	localparam int unsigned ST_RELAY     = 0;
	localparam int unsigned ST_LED       = 1;
	localparam int unsigned ST_AQ        = 4;
	localparam int unsigned ST_SCR       = 6;
	localparam int unsigned ST_STARS     = 9;
	localparam int unsigned ST_OK        = 10;
	localparam int unsigned ST_WIDE      = 11;
	localparam int unsigned ST_FAULT     = 12;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		AQ_GOOD = 2'h0,
		AQ_FAIR = 2'h1,
		AQ_POOR = 2'h2
	} co2ai_aq_type;

	typedef enum logic [2:0] {
		SCR_INFO = 3'h1,
		SCR_OUT  = 3'h2,
		SCR_MEAS = 3'h4
	} co2ai_scr_type;

endpackage : co2ai_pkg

// ### pkg/co2ai_seq_if.sv
interface co2ai_seq_if;
	import co2ai_pkg::*;
	logic          tick;
	logic [1:0]    outcfg;
	logic [3:0]    fault;
	logic          present;
	co2ai_scr_type scr;
	logic [1:0]    out_idx;
	logic [1:0]    err_idx;
	logic          stars;
	logic          startup_ok;

	modport ctl (output tick, outcfg, fault, present,
		input scr, out_idx, err_idx, stars, startup_ok);
	modport seq (input tick, outcfg, fault, present,
		output scr, out_idx, err_idx, stars, startup_ok);
endinterface : co2ai_seq_if

// ### logic/co2ai_seq.sv
module co2ai_seq (
	// Clock and reset
	input wire logic     clk,
	input wire logic     rst,
	// Sequencer link
	co2ai_seq_if.seq     sif
);
	import co2ai_pkg::*;

	typedef struct packed {
		co2ai_scr_type scr;
		logic [1:0]    out_idx;
		logic [1:0]    err_idx;
		logic [3:0]    cause;
		logic          startup_ok;
		logic          stars;
	} co2ai_seq_st_type;

	co2ai_seq_st_type s_q;
	co2ai_seq_st_type s_d;
	logic [3:0]       active;

	// Nearest active entry after cur, wrapping; cur itself if none other.
	function automatic logic [1:0] co2ai_next(input logic [3:0] v, input logic [1:0] cur);
		logic [1:0] r;
		logic [1:0] k;
		r = cur;
		for (int i = 3; i >= 1; i--) begin
			k = cur + 2'(i);
			if (v[k]) begin
				r = k;
			end
		end
		return r;
	endfunction : co2ai_next

	// ==========================================================
	// Screen sequence
	// The startup cause stays latched until reset so it is never lost once shown.
	assign active = s_q.cause | sif.fault;

	always_comb begin
		s_d = s_q;
		unique case (s_q.scr)
			SCR_INFO: begin
				s_d.startup_ok = sif.present && (sif.fault == 4'h0);
				if (sif.tick) begin
					s_d.cause = sif.fault | (sif.present ? 4'h0 : FAULT_NOMOD);
					if (sif.outcfg[0]) begin
						s_d.scr     = SCR_OUT;
						s_d.out_idx = 2'h0;
					end else if (sif.outcfg[1]) begin
						s_d.scr     = SCR_OUT;
						s_d.out_idx = 2'h1;
					end else begin
						s_d.scr = SCR_MEAS;
					end
				end
			end
			SCR_OUT: begin
				if (sif.tick) begin
					if (s_q.out_idx == 2'h0 && sif.outcfg[1]) begin
						s_d.out_idx = 2'h1;
					end else begin
						s_d.scr     = SCR_MEAS;
						s_d.err_idx = co2ai_next(active, 2'h3);
					end
				end
			end
			SCR_MEAS: begin
				if (sif.tick) begin
					s_d.err_idx = co2ai_next(active, s_q.err_idx);
				end else if (!active[s_q.err_idx]) begin
					s_d.err_idx = co2ai_next(active, s_q.err_idx);
				end
			end
			default: s_d.scr = SCR_INFO;
		endcase
		s_d.stars = (s_d.scr == SCR_MEAS) && ((s_d.cause | sif.fault) != 4'h0);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '{scr: SCR_INFO, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign sif.scr        = s_q.scr;
	assign sif.out_idx    = s_q.out_idx;
	assign sif.err_idx    = s_q.err_idx;
	assign sif.stars      = s_q.stars;
	assign sif.startup_ok = s_q.startup_ok;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_stars_on_fault: assert property (s_q.scr == SCR_MEAS && sif.fault != 4'h0
		|=> s_q.stars) else $error("fault not starred");
	a_fault_rotates: assert property (s_q.scr == SCR_MEAS && sif.tick
		&& $countones(active) > 1 && $stable(sif.fault)
		|=> s_q.err_idx != $past(s_q.err_idx)) else $error("faults not rotated");
	a_info_to_meas: assert property (s_q.scr == SCR_INFO && sif.tick && sif.outcfg == 2'h0
		|=> s_q.scr == SCR_MEAS) else $error("no measurement screen");
	a_out_screens: assert property (s_q.scr == SCR_INFO && sif.tick && sif.outcfg == 2'h3
		|=> s_q.scr == SCR_OUT && s_q.out_idx == 2'h0) else $error("output screen skipped");
endmodule : co2ai_seq

// ### logic/co2ai_top.sv
module co2ai_top #(
	parameter int unsigned SCREEN_CYCLES = co2ai_pkg::SCREEN_CYC,
	parameter int unsigned BLINK_CYCLES  = co2ai_pkg::BLINK_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Measurement module
	input  wire logic [15:0] meas_ppm,
	input  wire logic [15:0] meas_temp_c,
	input  wire logic [3:0]  meas_fault,
	input  wire logic        module_present,
	// Switches
	input  wire logic [3:0]  rot_sw,
	input  wire logic        range_wide_sw,
	// Relay and LEDs
	output logic             relay_on,
	output logic             relay_led,
	output logic             led_top,
	output logic             led_mid,
	output logic             led_bot,
	// Display
	output logic [15:0]      disp_ppm,
	output logic [15:0]      disp_temp_c,
	output logic [1:0]       disp_aq,
	output logic [2:0]       disp_screen,
	output logic [1:0]       disp_out_idx,
	output logic [1:0]       disp_err_idx,
	output logic             disp_stars,
	output logic             disp_startup_ok
);
	import co2ai_pkg::*;

	typedef struct packed {
		logic [15:0]  conc;
		logic [15:0]  temp;
		logic [15:0]  sp;
		logic         relay;
		logic         relay_led;
		logic         led_top;
		logic         led_mid;
		logic         led_bot;
		co2ai_aq_type aq;
		logic         blink;
		logic [31:0]  blink_cnt;
		logic [31:0]  dwell_cnt;
		logic         tick;
		logic [1:0]   outcfg;
		logic         awrdy;
		logic         wrdy;
		logic         aw_have;
		logic         w_have;
		logic [7:0]   awaddr;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         arrdy;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
	} co2ai_st_type;

	co2ai_st_type s_q;
	co2ai_st_type s_d;
	co2ai_seq_if  sif ();
	logic [15:0]  span;
	logic [33:0]  wr_look;

	co2ai_seq u_seq (
		.clk (clk),
		.rst (rst),
		.sif (sif)
	);

	assign sif.tick    = s_q.tick;
	assign sif.outcfg  = s_q.outcfg;
	assign sif.fault   = meas_fault;
	assign sif.present = module_present;

	// Narrow span clips the reading so LEDs and relay see what the display shows.
	assign span = range_wide_sw ? SPAN_WIDE : SPAN_NARROW;

	function automatic logic [33:0] co2ai_rd(input logic [7:0] a, input co2ai_st_type s);
		logic [31:0] st;
		st = '0;
		st[ST_RELAY]          = s.relay;
		st[ST_LED +: 3]       = {s.led_bot, s.led_mid, s.led_top};
		st[ST_AQ +: 2]        = s.aq;
		st[ST_SCR +: 3]       = sif.scr;
		st[ST_STARS]          = sif.stars;
		st[ST_OK]             = sif.startup_ok;
		st[ST_WIDE]           = range_wide_sw;
		st[ST_FAULT +: 4]     = meas_fault;
		unique case (a)
			ADDR_CONC:   return {RESP_OKAY, 16'h0000, s.conc};
			ADDR_STATUS: return {RESP_OKAY, st};
			ADDR_OUTCFG: return {RESP_OKAY, 30'h0000_0000, s.outcfg};
			ADDR_SETPT:  return {RESP_OKAY, 16'h0000, s.sp};
			ADDR_TEMP:   return {RESP_OKAY, 16'h0000, s.temp};
			default:     return {RESP_SLVERR, 32'h0000_0000};
		endcase
	endfunction : co2ai_rd

	// A call result cannot be sliced, so the write lookup lands in a net first.
	assign wr_look = co2ai_rd(s_q.awaddr, s_q);

	// ==========================================================
	// Measurement, relay, LEDs and timers
	always_comb begin
		s_d      = s_q;
		s_d.conc = (meas_ppm > span) ? span : meas_ppm;
		s_d.temp = meas_temp_c;
		s_d.sp   = (rot_sw <= 4'h9) ? SETPT_TAB[rot_sw] : SETPT_TAB[0];
		if (!s_q.relay && s_q.conc > s_q.sp + HYST_PPM) begin
			s_d.relay = 1'b1;
		end else if (s_q.relay && s_q.conc < s_q.sp - HYST_PPM) begin
			s_d.relay = 1'b0;
		end
		s_d.relay_led = s_d.relay;
		s_d.led_bot   = s_q.conc <= LVL_LOW;
		s_d.led_mid   = s_q.conc > LVL_LOW && s_q.conc <= LVL_HIGH;
		s_d.led_top   = (s_q.conc > LVL_TOP) ? s_q.blink : (s_q.conc > LVL_HIGH);
		if (s_q.conc <= LVL_LOW) begin
			s_d.aq = AQ_GOOD;
		end else if (s_q.conc <= LVL_HIGH) begin
			s_d.aq = AQ_FAIR;
		end else begin
			s_d.aq = AQ_POOR;
		end
		if (s_q.blink_cnt >= BLINK_CYCLES - 1) begin
			s_d.blink_cnt = '0;
			s_d.blink     = !s_q.blink;
		end else begin
			s_d.blink_cnt = s_q.blink_cnt + 32'h0000_0001;
		end
		s_d.tick = 1'b0;
		if (s_q.dwell_cnt >= SCREEN_CYCLES - 1) begin
			s_d.dwell_cnt = '0;
			s_d.tick      = 1'b1;
		end else begin
			s_d.dwell_cnt = s_q.dwell_cnt + 32'h0000_0001;
		end

		// ==========================================================
		// AXI4-Lite slave
		if (s_axi_awvalid && s_q.awrdy) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wrdy) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wr_look[33:32];
			if (s_q.awaddr == ADDR_OUTCFG && s_q.wstrb[0]) begin
				s_d.outcfg = s_q.wdata[1:0];
			end
		end
		s_d.awrdy = !s_d.aw_have && !s_d.bvalid;
		s_d.wrdy  = !s_d.w_have && !s_d.bvalid;
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.arrdy) begin
			s_d.rvalid = 1'b1;
			{s_d.rresp, s_d.rdata} = co2ai_rd(s_axi_araddr, s_q);
		end
		s_d.arrdy = !s_d.rvalid;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '{sp: SETPT_TAB[0], outcfg: OUTCFG_RST, aq: AQ_GOOD, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready   = s_q.awrdy;
	assign s_axi_wready    = s_q.wrdy;
	assign s_axi_bvalid    = s_q.bvalid;
	assign s_axi_bresp     = s_q.bresp;
	assign s_axi_arready   = s_q.arrdy;
	assign s_axi_rvalid    = s_q.rvalid;
	assign s_axi_rdata     = s_q.rdata;
	assign s_axi_rresp     = s_q.rresp;
	assign relay_on        = s_q.relay;
	assign relay_led       = s_q.relay_led;
	assign led_top         = s_q.led_top;
	assign led_mid         = s_q.led_mid;
	assign led_bot         = s_q.led_bot;
	assign disp_ppm        = s_q.conc;
	assign disp_temp_c     = s_q.temp;
	assign disp_aq         = s_q.aq;
	assign disp_screen     = sif.scr;
	assign disp_out_idx    = sif.out_idx;
	assign disp_err_idx    = sif.err_idx;
	assign disp_stars      = sif.stars;
	assign disp_startup_ok = sif.startup_ok;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_relay_closes: assert property (!s_q.relay && s_q.conc > s_q.sp + HYST_PPM
		|=> s_q.relay) else $error("relay did not close");
	a_relay_holds: assert property (s_q.relay && s_q.conc >= s_q.sp - HYST_PPM
		|=> s_q.relay) else $error("relay opened inside band");
	a_setpt_decode: assert property (rot_sw == 4'h5 |=> s_q.sp == 16'h04B0)
		else $error("setpoint decode wrong");
	a_relay_led_eq: assert property (relay_on == relay_led)
		else $error("relay LED mismatch");
	a_top_blink: assert property (s_q.conc > LVL_TOP |=> s_q.led_top == $past(s_q.blink))
		else $error("top LED not blinking");
	a_mid_band: assert property (s_q.conc > LVL_LOW && s_q.conc <= LVL_HIGH
		|=> s_q.led_mid && !s_q.led_bot && !s_q.led_top) else $error("middle LED wrong");
	a_bot_band: assert property (s_q.conc <= LVL_LOW |=> s_q.led_bot && !s_q.led_mid)
		else $error("bottom LED wrong");
	a_class_poor: assert property (s_q.conc > LVL_HIGH |=> s_q.aq == AQ_POOR)
		else $error("class not poor");
	a_range_clip: assert property (!range_wide_sw && meas_ppm > SPAN_NARROW
		|=> s_q.conc == SPAN_NARROW) else $error("narrow span not clipped");
endmodule : co2ai_top

// ### sim/co2ai_meas_model.sv
module co2ai_meas_model (
	// Clock
	input  wire logic   clk,
	// Readings
	output logic [15:0] meas_ppm,
	output logic [15:0] meas_temp_c,
	output logic [3:0]  meas_fault,
	output logic        module_present
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] ppm_q;

	// ==========
	// Lines
	initial begin
		ppm_q          = 16'h0190;
		meas_temp_c    = 16'h0015;
		meas_fault     = 4'h0;
		module_present = 1'b1;
	end

	// A missing module leaves its ppm reading lines floating, so they wander every cycle; temperature holds.
	always @(posedge clk) begin
		meas_ppm <= module_present ? ppm_q : ~meas_ppm;
	end

	// ==========
	// Controls
	task set_ppm(input logic [15:0] v);
		@(posedge clk);
		ppm_q <= v;
	endtask : set_ppm

	task set_state(input logic [15:0] t, input logic [3:0] f, input logic p);
		@(posedge clk);
		meas_temp_c    <= t;
		meas_fault     <= f;
		module_present <= p;
	endtask : set_state
endmodule : co2ai_meas_model

// ### sim/co2ai_test.sv
module co2ai_test;
	timeunit 1ns;
	timeprecision 1ps;
	import co2ai_pkg::*;

	localparam int unsigned SCR_N = 20;
	localparam logic [15:0] PPM_T [6] = '{16'h0000, 16'h0320, 16'h0321, 16'h04B0,
		16'h04B1, 16'h07D0};
	localparam logic [4:0]  LED_T [6] = '{5'h04, 5'h04, 5'h09, 5'h09, 5'h12, 5'h12};
	localparam logic [15:0] RLY_P [5] = '{16'h03B5, 16'h041A, 16'h041B, 16'h03B6, 16'h03B5};
	localparam logic        RLY_E [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	localparam logic [15:0] SP_T [11] = '{16'h0258, 16'h02BC, 16'h0320, 16'h0384,
		16'h03E8, 16'h04B0, 16'h0578, 16'h0640, 16'h0708, 16'h07D0, 16'h0258};

	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, range_wide_sw;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, disp_aq, disp_out_idx, disp_err_idx;
	logic [15:0] meas_ppm, meas_temp_c, disp_ppm, disp_temp_c;
	logic [3:0]  meas_fault, rot_sw;
	logic        module_present, relay_on, relay_led, led_top, led_mid, led_bot;
	logic [2:0]  disp_screen;
	logic        disp_stars, disp_startup_ok;
	logic [4:0]  scr_key;
	logic [4:0]  scr_log[$];
	int          fails;
	int          checks_done;

	co2ai_top #(.SCREEN_CYCLES(SCR_N), .BLINK_CYCLES(4)) u_co2ai_top (
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas_ppm(meas_ppm), .meas_temp_c(meas_temp_c), .meas_fault(meas_fault),
		.module_present(module_present), .rot_sw(rot_sw), .range_wide_sw(range_wide_sw),
		.relay_on(relay_on), .relay_led(relay_led), .led_top(led_top), .led_mid(led_mid),
		.led_bot(led_bot), .disp_ppm(disp_ppm), .disp_temp_c(disp_temp_c),
		.disp_aq(disp_aq), .disp_screen(disp_screen), .disp_out_idx(disp_out_idx),
		.disp_err_idx(disp_err_idx), .disp_stars(disp_stars),
		.disp_startup_ok(disp_startup_ok));

	co2ai_meas_model u_co2ai_meas_model (.clk(clk), .meas_ppm(meas_ppm),
		.meas_temp_c(meas_temp_c), .meas_fault(meas_fault), .module_present(module_present));

	// ==========
	// Clock and screen log
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// The output index only matters on the output screen, so it is masked elsewhere.
	assign scr_key = {disp_screen, (disp_screen == SCR_OUT) ? disp_out_idx : 2'h0};

	always @(posedge clk) begin
		if (rst)
			scr_log.delete();
		else if (scr_log.size() == 0 || scr_log[$] !== scr_key)
			scr_log.push_back(scr_key);
	end

	// ==========
	// Checks
	task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check_word

	task check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check_resp

	task check_log(input logic [4:0] exp[$]);
		check_word("screen count", 32'(exp.size()), 32'(scr_log.size()));
		foreach (exp[i])
			check_word("screen", 32'(exp[i]), 32'(scr_log[i]));
	endtask : check_log

	task tally_and_finish;
		$display("Checks made: %0d, errors: %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// ==========
	// Bus access
	task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_read

	task do_reset(input logic p);
		u_co2ai_meas_model.set_state(16'h0015, 4'h0, p);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset

	task wait_meas;
		int n;
		n = 0;
		while (disp_screen !== SCR_MEAS && n < 500) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
	endtask : wait_meas

	task settle(input logic [15:0] v);
		u_co2ai_meas_model.set_ppm(v);
		repeat (5) @(posedge clk);
	endtask : settle

	// ==========
	// Tests
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          hi;
		bit   [3:0]  seen;
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, rot_sw, range_wide_sw} = 53'h0_0000_0000_0001;
		fails = 0;
		checks_done = 0;
		do_reset(1'b1);
		axi_read(ADDR_OUTCFG, d, r);
		check_word("outcfg reset", 32'h0000_0001, d);
		axi_read(ADDR_SETPT, d, r);
		check_word("setpoint default", 32'h0000_0258, d);
		check_word("startup ok", 32'h0000_0001, 32'(disp_startup_ok));
		axi_write(ADDR_OUTCFG, 32'h0000_0003, r);
		wait_meas();
		check_log('{5'h04, 5'h08, 5'h09, 5'h10});
		check_word("stars idle", 32'h0000_0000, 32'(disp_stars));
		for (int i = 0; i < 6; i++) begin
			settle(PPM_T[i]);
			check_word("levels", 32'(LED_T[i]), 32'({led_top, led_mid, led_bot, disp_aq}));
		end
		settle(16'h09C4);
		hi = 0;
		repeat (16) begin
			@(posedge clk);
			hi += int'(led_top === 1'b1);
		end
		check_word("top blink", 32'h0000_0001, 32'(hi > 0 && hi < 16));
		check_word("blink others", 32'h0000_0002, 32'({led_mid, led_bot, disp_aq}));
		rot_sw <= 4'h4;
		for (int i = 0; i < 5; i++) begin
			settle(RLY_P[i]);
			check_word("relay", 32'(RLY_E[i]), 32'(relay_on));
			check_word("relay led", 32'(RLY_E[i]), 32'(relay_led));
		end
		for (int i = 0; i < 11; i++) begin
			rot_sw <= (i == 10) ? 4'hC : 4'(i);
			repeat (4) @(posedge clk);
			axi_read(ADDR_SETPT, d, r);
			check_word("setpoint", 32'(SP_T[i]), d);
		end
		range_wide_sw <= 1'b0;
		settle(16'h0BB8);
		check_word("narrow span", 32'h0000_07D0, 32'(disp_ppm));
		range_wide_sw <= 1'b1;
		settle(16'h1770);
		check_word("wide span", 32'h0000_1388, 32'(disp_ppm));
		u_co2ai_meas_model.set_state(16'h0017, 4'h0, 1'b1);
		repeat (5) @(posedge clk);
		check_word("temp shown", 32'h0000_0017, 32'(disp_temp_c));
		axi_read(ADDR_TEMP, d, r);
		check_word("temp reg", 32'h0000_0017, d);
		axi_read(8'h40, d, r);
		check_resp("unmapped read", RESP_SLVERR, r);
		check_word("unmapped data", 32'h0000_0000, d);
		axi_write(8'h44, 32'h0000_0001, r);
		check_resp("unmapped write", RESP_SLVERR, r);
		axi_write(ADDR_CONC, 32'h0000_0123, r);
		check_resp("read-only write", RESP_OKAY, r);
		axi_read(ADDR_CONC, d, r);
		check_word("conc kept", 32'h0000_1388, d);
		u_co2ai_meas_model.set_state(16'h0017, 4'h6, 1'b1);
		repeat (5) @(posedge clk);
		check_word("fault stars", 32'h0000_0001, 32'(disp_stars));
		seen = 4'h0;
		repeat (3 * SCR_N) begin
			@(posedge clk);
			seen[disp_err_idx] = 1'b1;
		end
		check_word("fault rotation", 32'h0000_0006, 32'(seen));
		do_reset(1'b0);
		repeat (3) @(posedge clk);
		check_word("startup error", 32'h0000_0000, 32'(disp_startup_ok));
		wait_meas();
		check_log('{5'h04, 5'h08, 5'h10});
		check_word("cause shown", 32'h0000_0001, 32'(disp_stars));
		check_word("cause index", 32'h0000_0000, 32'(disp_err_idx));
		do_reset(1'b1);
		axi_write(ADDR_OUTCFG, 32'h0000_0000, r);
		check_resp("outcfg write", RESP_OKAY, r);
		wait_meas();
		check_log('{5'h04, 5'h10});
		check_word("startup ok kept", 32'h0000_0001, 32'(disp_startup_ok));
		check_word("no cause", 32'h0000_0000, 32'(disp_stars));
		tally_and_finish();
	end

	// A hang anywhere above ends the run here instead.
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
endmodule : co2ai_test
